// >>> rtl/adcsq_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the sequence select and host port block.
// ----------------------------------------------------------------------------
package adcsq_pkg;

  // Number of converter channels.
  localparam int unsigned NCHAN = 4;
  // Width of the converted result and of the host data bus.
  localparam int unsigned DATA_W = 14;
  // Width of the channel index.
  localparam int unsigned CHAN_W = 2;
  // Master clock cycles per channel conversion.
  localparam int unsigned CONV_CYCLES = 16;
  // Width of the conversion cycle counter.
  localparam int unsigned CNT_W = 5;
  // Counter value at which a channel conversion completes.
  localparam logic [CNT_W-1:0] CNT_LAST = 5'(CONV_CYCLES - 1);
  // Counter reset value.
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  // Internal master clock divider ratio (system clocks per master tick).
  localparam int unsigned INT_DIV = 2;
  // Width of the internal divider.
  localparam int unsigned DIV_W = 2;
  // Last count of the internal divider.
  localparam logic [DIV_W-1:0] DIV_LAST = 2'(INT_DIV - 1);
  // Divider reset value.
  localparam logic [DIV_W-1:0] DIV_ZERO = 2'h0;
  // Channel mask reset value: all channels selected.
  localparam logic [NCHAN-1:0] MASK_RST = 4'hf;
  // Empty channel set.
  localparam logic [NCHAN-1:0] MASK_NONE = 4'h0;
  // Depth of the result FIFO.
  localparam int unsigned FIFO_DEPTH = 8;
  // Clock-source choice value that selects the internal master clock.
  localparam logic CLK_INTERNAL = 1'b0;

  // Sequencer states.
  typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_CONV, ADCSQ_STORE} adcsq_state_t;

endpackage

// >>> rtl/adcsq_fifo.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Result FIFO with valid and ready on both sides.
// ----------------------------------------------------------------------------
module adcsq_fifo
#(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
)
(
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  // Storage array, written only when a word is accepted.
  logic [WIDTH-1:0] mem_reg [DEPTH];
  // Read and write pointers and the fill level.
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  // Transfer strobes on each side.
  wire              push;
  wire              pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  // Pointers wrap at the depth, which need not be a power of two.
  function automatic logic [AW-1:0] adcsq_inc(input logic [AW-1:0] p);
    adcsq_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Pointer and level bookkeeping.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= adcsq_inc(wr_ptr_reg);
      if (pop)
        rd_ptr_reg <= adcsq_inc(rd_ptr_reg);
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

  // Data storage has no reset; only accepted words are ever read.
  always_ff @(posedge clock)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

endmodule

// >>> rtl/adcsq_top.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Sequence select, conversion timing and host port of a four-channel
// simultaneous-sampling converter.
// ----------------------------------------------------------------------------

module adcsq_top
  import adcsq_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic [NCHAN-1:0]  data_in,
  output      logic [DATA_W-1:0] data_out,
  output      logic              data_oe,
  input  wire logic              sw_select,
  input  wire logic              clk_in_sl1,
  input  wire logic              clock_source_choice,
  input  wire logic              hw_include_chan3,
  input  wire logic              hw_include_chan4,
  input  wire logic              power_save_n,
  input  wire logic              conversion_start,
  input  wire logic [DATA_W-1:0] result_in,
  output      logic              busy,
  output      logic              eoc_n,
  output      logic              track_hold,
  output      logic [CHAN_W-1:0] conv_channel,
  output      logic              result_overflow
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------

  // Bundle of all asynchronous pins, first and second flop stages.
  localparam int unsigned SYN_W = NCHAN + 10;
  logic [SYN_W-1:0] syn1_reg;
  logic [SYN_W-1:0] syn2_reg;
  // Delayed copy of the second stage, used only for edge detection.
  logic [SYN_W-1:0] syn3_reg;
  // Idle level of every pin: strobes high, standby input high, the rest low.
  // Resetting to the idle level keeps the drive enable off during reset and
  // stops a false write or read edge from appearing just after release.
  localparam logic [SYN_W-1:0] SYN_IDLE = {MASK_NONE, 3'h7, 7'h02};

  // Two flops before any logic reads a pin; the third gives edges.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      syn1_reg <= SYN_IDLE;
      syn2_reg <= SYN_IDLE;
      syn3_reg <= SYN_IDLE;
    end
    else
    begin
      syn1_reg <= {data_in, cs_n, rd_n, wr_n, sw_select, clk_in_sl1,
                   clock_source_choice, hw_include_chan3, hw_include_chan4,
                   power_save_n, conversion_start};
      syn2_reg <= syn1_reg;
      syn3_reg <= syn2_reg;
    end
  end

  // Named views of the synchronised pins.
  wire [NCHAN-1:0] s_data   = syn2_reg[SYN_W-1:10];
  wire             s_cs_n   = syn2_reg[9];
  wire             s_rd_n   = syn2_reg[8];
  wire             s_wr_n   = syn2_reg[7];
  wire             s_swsel  = syn2_reg[6];
  wire             s_clkin  = syn2_reg[5];
  wire             s_clksrc = syn2_reg[4];
  wire             s_inc3   = syn2_reg[3];
  wire             s_inc4   = syn2_reg[2];
  wire             s_run    = syn2_reg[1];
  wire             s_start  = syn2_reg[0];
  // Rising edges of the write strobe, the shared clock pin and start.
  wire             wr_rise    = s_wr_n && !syn3_reg[7];
  wire             clkin_rise = s_clkin && !syn3_reg[5];
  wire             start_rise = s_start && !syn3_reg[0];

  // --------------------------------------------------------------------------
  // Host port
  // --------------------------------------------------------------------------

  // Channel mask written by the host, bit 0 standing for channel 1.
  logic [NCHAN-1:0] mask_reg;

  // qualified write capture
  // The data lines are sampled with the strobe, so both see equal delay.
  wire write_ok = wr_rise && !s_cs_n && s_rd_n;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      mask_reg <= MASK_RST;
    else if (write_ok)
      mask_reg <= s_data;
  end

  // gated output enable
  // Enable is combinational on the synchronised strobes; a read held with
  // write low is a host fault and the pins still follow chip select and read.
  assign data_oe = !s_cs_n && !s_rd_n;

  // --------------------------------------------------------------------------
  // Clock selection and master clock enable
  // --------------------------------------------------------------------------

  // Internal divider producing the internal master tick.
  logic [DIV_W-1:0] div_reg;
  wire              int_tick = (div_reg == DIV_LAST);

  // Free-running divider, one-cycle enable at its last count.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      div_reg <= DIV_ZERO;
    else
      div_reg <= int_tick ? DIV_ZERO : div_reg + 1'b1;
  end

  wire use_ext = s_swsel && (s_clksrc != CLK_INTERNAL);
  wire tick    = use_ext ? clkin_rise : int_tick;

  // --------------------------------------------------------------------------
  // Channel selection
  // --------------------------------------------------------------------------

  wire [NCHAN-1:0] hw_sel  = {s_inc4, s_inc3, s_clksrc, s_clkin};
  wire [NCHAN-1:0] new_sel = s_swsel ? mask_reg : hw_sel;

  // Lowest pending channel, encoded as an index.
  function automatic logic [CHAN_W-1:0] adcsq_first(input logic [NCHAN-1:0] m);
    adcsq_first = '0;
    for (int i = NCHAN - 1; i >= 0; i--)
      if (m[i])
        adcsq_first = CHAN_W'(i);
  endfunction

  // --------------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------------

  adcsq_state_t      state_reg;
  adcsq_state_t      state_next;
  // Channels still to convert in this sequence.
  logic [NCHAN-1:0]  pend_reg;
  logic [NCHAN-1:0]  pend_next;
  // Master cycle count within the current channel.
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  // End-of-conversion pulse and captured result word.
  logic              eoc_reg;
  logic [DATA_W-1:0] res_reg;
  logic              ovf_reg;
  // FIFO handshake signals.
  logic              fifo_ready;
  logic              fifo_valid;
  logic [DATA_W-1:0] fifo_data;

  wire [CHAN_W-1:0] cur_chan  = adcsq_first(pend_reg);
  wire              chan_done = (state_reg == ADCSQ_CONV) && tick && (cnt_reg == CNT_LAST);
  // A finished word waits in STORE until the FIFO takes it.
  wire              push      = (state_reg == ADCSQ_STORE);
  wire              stored    = push && fifo_ready;

  // Next-state logic of the sequencer.
  always_comb
  begin
    state_next = state_reg;
    pend_next  = pend_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ADCSQ_IDLE:
      begin
        if (start_rise && s_run && (new_sel != MASK_NONE))
        begin
          state_next = ADCSQ_CONV;
          pend_next  = new_sel;
          cnt_next   = CNT_ZERO;
        end
      end
      ADCSQ_CONV:
      begin
        if (chan_done)
          state_next = ADCSQ_STORE;
        else if (tick)
          cnt_next = cnt_reg + 1'b1;
      end
      ADCSQ_STORE:
      begin
        if (stored)
        begin
          pend_next = pend_reg & ~(NCHAN'(1) << cur_chan);
          cnt_next  = CNT_ZERO;
          state_next = (pend_next == MASK_NONE) ? ADCSQ_IDLE : ADCSQ_CONV;
        end
      end
      default:
        state_next = ADCSQ_IDLE;
    endcase
  end

  // Sequencer state registers.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ADCSQ_IDLE;
      pend_reg  <= MASK_NONE;
      cnt_reg   <= CNT_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      pend_reg  <= pend_next;
      cnt_reg   <= cnt_next;
    end
  end

  // per-channel end pulse
  // The result is latched with the pulse so readout sees a stable word.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      eoc_reg <= 1'b0;
      res_reg <= '0;
      ovf_reg <= 1'b0;
    end
    else
    begin
      eoc_reg <= chan_done;
      if (chan_done)
        res_reg <= result_in;
      // Flags a word that sat waiting on a full FIFO.
      if (push && !fifo_ready)
        ovf_reg <= 1'b1;
      else if (start_rise)
        ovf_reg <= 1'b0;
    end
  end

  assign busy         = (state_reg != ADCSQ_IDLE);
  assign eoc_n        = !eoc_reg;
  assign track_hold   = busy;
  assign conv_channel = cur_chan;
  assign result_overflow = ovf_reg;

  // --------------------------------------------------------------------------
  // Result buffer and readout
  // --------------------------------------------------------------------------

  // A read ends on the release of the strobe and pops one word.
  wire read_end = !s_cs_n && s_rd_n && !syn3_reg[8] && fifo_valid;

  adcsq_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) adcsq_fifo_inst
  (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (res_reg),
    .out_valid (fifo_valid),
    .out_ready (read_end),
    .out_data  (fifo_data)
  );

  // Output word register follows the FIFO head.
  logic [DATA_W-1:0] dout_reg;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      dout_reg <= '0;
    else
      dout_reg <= fifo_valid ? fifo_data : '0;
  end
  assign data_out = dout_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------

  sequence start_seq;
    (state_reg == ADCSQ_IDLE) && start_rise && s_run && (new_sel != MASK_NONE);
  endsequence

  sequence busy_seq;
    busy [*2];
  endsequence

  // The enable must follow the pins as they were two clocks ago.
  oe_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    data_oe == (!$past(cs_n, 2) && !$past(rd_n, 2))) else $error("output enable wrong");

  mask_write_a: assert property (@(posedge clock) disable iff (!nrst)
    write_ok |=> mask_reg == $past(s_data)) else $error("mask not written");

  mask_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    !write_ok |=> $stable(mask_reg)) else $error("mask changed");

  start_busy_a: assert property (@(posedge clock) disable iff (!nrst)
    start_seq |=> busy_seq) else $error("busy not raised");

  standby_a: assert property (@(posedge clock) disable iff (!nrst)
    (!busy && !s_run) |=> !busy) else $error("started in standby");

  capture_a: assert property (@(posedge clock) disable iff (!nrst)
    start_seq |=> pend_reg == $past(new_sel)) else $error("selection lost");

  eoc_pulse_a: assert property (@(posedge clock) disable iff (!nrst)
    chan_done |=> !eoc_n ##1 eoc_n) else $error("end pulse wrong");

  hw_clock_a: assert property (@(posedge clock) disable iff (!nrst)
    !s_swsel |-> tick == int_tick) else $error("hardware mode clock");

  sixteen_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == ADCSQ_CONV) && tick && !chan_done |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("count not sixteen");

  count_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == ADCSQ_CONV) && !tick |=> $stable(cnt_reg)) else $error("count moved");

  count_entry_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(state_reg == ADCSQ_CONV) |-> cnt_reg == CNT_ZERO) else $error("count not cleared");

  hw_pins_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == ADCSQ_IDLE) && start_rise && s_run && !s_swsel && (new_sel != MASK_NONE)
    |=> pend_reg == $past({s_inc4, s_inc3, s_clksrc, s_clkin})) else $error("pins not used");

  sw_mask_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == ADCSQ_IDLE) && start_rise && s_run && s_swsel && (new_sel != MASK_NONE)
    |=> pend_reg == $past(mask_reg)) else $error("mask not used");

endmodule

// >>> tb/adcsq_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Host processor model on the parallel port.
// ----------------------------------------------------------------------------
module adcsq_host_model
  import adcsq_pkg::*;
(
  input  wire logic              clock,
  output      logic              cs_n,
  output      logic              rd_n,
  output      logic              wr_n,
  output      logic [NCHAN-1:0]  data_in,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe
);
  // All strobes idle high from time zero.
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 4'h0;
  end

  // Moves just past a rising edge, where every strobe change is made.
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  // Writes the channel mask; strobes are held long enough for the synchronisers.
  task automatic write_mask(input logic [NCHAN-1:0] v);
    step(1);
    cs_n = 1'b0;
    data_in = v;
    wr_n = 1'b0;
    step(4);
    wr_n = 1'b1;
    step(4);
    cs_n = 1'b1;
    // Released lines show the inverse so a stale value cannot look valid.
    data_in = ~v;
    step(1);
  endtask

  // Reads one word; the release of the read strobe pops it.
  task automatic read_word(output logic [DATA_W-1:0] w, output logic oe);
    step(1);
    wr_n = 1'b1;
    cs_n = 1'b0;
    rd_n = 1'b0;
    step(4);
    w = data_out;
    oe = data_oe;
    rd_n = 1'b1;
    step(4);
    cs_n = 1'b1;
    step(1);
  endtask
endmodule

// >>> tb/adcsq_top_tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Self-checking bench for the sequence select and host port block.
// ----------------------------------------------------------------------------
module adcsq_top_tb;
  import adcsq_pkg::*;

  logic              clock = 1'b0;  // 20 MHz system clock.
  logic              nrst = 1'b0;   // Active-low reset.
  logic              cs_n, rd_n, wr_n;
  logic [NCHAN-1:0]  data_in;
  logic [DATA_W-1:0] data_out;
  logic              data_oe, busy, eoc_n, track_hold, result_overflow;
  logic              sw_select = 1'b1;
  logic              clk_in_sl1 = 1'b0;
  logic              clock_source_choice = 1'b0;
  logic              hw_include_chan3 = 1'b0;
  logic              hw_include_chan4 = 1'b0;
  logic              power_save_n = 1'b1;
  logic              conversion_start = 1'b0;
  logic [CHAN_W-1:0] conv_channel;
  logic [DATA_W-1:0] result_in;
  int                err_total = 0;  // Mismatches seen.
  int                num_checks = 0; // Comparisons made.
  int                cycles = 0;     // Timeout counter.

  // Each result carries its channel index so read order is visible.
  assign result_in = {12'h2a5, conv_channel};

  always #25 clock = ~clock;

  adcsq_top adcsq_top_inst (.clock(clock), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .sw_select(sw_select), .clk_in_sl1(clk_in_sl1),
    .clock_source_choice(clock_source_choice), .hw_include_chan3(hw_include_chan3),
    .hw_include_chan4(hw_include_chan4), .power_save_n(power_save_n),
    .conversion_start(conversion_start), .result_in(result_in), .busy(busy),
    .eoc_n(eoc_n), .track_hold(track_hold), .conv_channel(conv_channel),
    .result_overflow(result_overflow));

  adcsq_host_model adcsq_host_model_inst (.clock(clock), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  // ----------------------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // A hung wait would otherwise stall the run forever.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      final_report();
    end
  end

  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkw(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic pulse_start;
    conversion_start = 1'b1;
    step(4);
    conversion_start = 1'b0;
  endtask

  // Reads one word and checks the drive enable and the value.
  task automatic read_chk(input logic [CHAN_W-1:0] ch);
    logic [DATA_W-1:0] w;
    logic              oe;
    adcsq_host_model_inst.read_word(w, oe);
    chk1(oe, 1'b1);
    chkw(w, {12'h2a5, ch});
  endtask

  // Runs one sequence and checks channel order, count, timing and busy.
  // With ext set, the external clock is toggled every two system clocks.
  task automatic run_seq(input logic [NCHAN-1:0] exp, input logic ext);
    int          n, cyc, w;
    logic [2:0]  ch;
    n = 0;
    cyc = 0;
    ch = 3'h0;
    w = 0;
    pulse_start();
    while (busy !== 1'b1 && w < 10)
    begin
      step(1);
      w++;
    end
    chk1(busy, 1'b1);
    chk1(track_hold, 1'b1);
    // Include pins move after the start edge and must not matter now.
    hw_include_chan3 = ~hw_include_chan3;
    hw_include_chan4 = ~hw_include_chan4;
    if (!sw_select)
      clock_source_choice = ~clock_source_choice;
    if (!ext)
      clk_in_sl1 = ~clk_in_sl1;
    while (busy === 1'b1 && cyc < 3000)
    begin
      step(1);
      cyc++;
      if (ext)
        clk_in_sl1 = cyc[1];
      if (eoc_n === 1'b0)
      begin
        while (ch < 3'h4 && !exp[ch[1:0]])
          ch++;
        chkw(14'(conv_channel), 14'(ch));
        ch++;
        n++;
        if (n == 1 && ext)
          chk1((cyc / 4) inside {[16:17]}, 1'b1);
        if (n == 1 && !ext)
          chk1(cyc inside {[30:34]}, 1'b1);
      end
    end
    chkw(14'(n), 14'($countones(exp)));
    chk1(busy, 1'b0);
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset;
    chk1(busy, 1'b0);
    chk1(eoc_n, 1'b1);
    chk1(data_oe, 1'b0);
  endtask

  // Software mode, written mask with gaps, internal clock.
  task automatic t_soft;
    sw_select = 1'b1;
    clock_source_choice = CLK_INTERNAL;
    adcsq_host_model_inst.write_mask(4'h5);
    run_seq(4'h5, 1'b0);
    run_seq(4'h5, 1'b0);
    chk1(result_overflow, 1'b0);
    read_chk(2'h0);
    read_chk(2'h2);
    read_chk(2'h0);
    read_chk(2'h2);
  endtask

  // Hardware mode: the clock pin and the chan4 pin pick channels 1 and 4; the internal clock is used.
  task automatic t_hard;
    sw_select = 1'b0;
    clk_in_sl1 = 1'b1;
    clock_source_choice = 1'b0;
    hw_include_chan3 = 1'b0;
    hw_include_chan4 = 1'b1;
    step(4);
    run_seq(4'h9, 1'b0);
    read_chk(2'h0);
    read_chk(2'h3);
  endtask

  // Software mode with the external conversion clock.
  task automatic t_ext;
    sw_select = 1'b1;
    clock_source_choice = 1'b1;
    clk_in_sl1 = 1'b0;
    adcsq_host_model_inst.write_mask(4'h2);
    run_seq(4'h2, 1'b1);
    read_chk(2'h1);
    clock_source_choice = CLK_INTERNAL;
  endtask

  // Standby refuses a start.
  task automatic t_standby;
    power_save_n = 1'b0;
    step(2);
    pulse_start();
    step(8);
    chk1(busy, 1'b0);
    power_save_n = 1'b1;
    step(2);
  endtask

  // Fill the buffer until the sequencer stalls, then drain it.
  task automatic t_fill;
    int w;
    w = 0;
    adcsq_host_model_inst.write_mask(4'hf);
    run_seq(4'hf, 1'b0);
    run_seq(4'hf, 1'b0);
    pulse_start();
    step(300);
    chk1(result_overflow, 1'b1);
    chk1(busy, 1'b1);
    for (int i = 0; i < 8; i++)
      read_chk(2'(i));
    while (busy === 1'b1 && w < 600)
    begin
      step(1);
      w++;
    end
    chk1(busy, 1'b0);
    for (int i = 0; i < 4; i++)
      read_chk(2'(i));
  endtask

  // Main sequence: reset for 16 cycles, settle, then each scenario.
  initial
  begin
    step(16);
    chk1(data_oe, 1'b0);
    nrst = 1'b1;
    step(3);
    t_reset();
    t_soft();
    t_hard();
    t_ext();
    t_standby();
    t_fill();
    final_report();
  end
endmodule
